// ==== rtl/t1fmt_core.sv ====
// core: t1 f-bit overhead insertion and extraction, robbed-bit signaling, performance report build
`timescale 1ns/1ps
module t1fmt_core #(
   parameter int FIFO_DEPTH = 4
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire t1fmt_pkg::t1fmt_mode_e mode,
   input wire t1fmt_pkg::t1fmt_sig_e sig_variant,
   input wire logic tx_data_in,
   input wire t1fmt_pkg::t1fmt_sig_s tx_sig,
   input wire t1fmt_pkg::t1fmt_scfield_s tx_scfield,
   input wire logic [7:0] tx_link_octet,
   input wire logic tx_link_valid,
   output logic tx_link_ready,
   input wire t1fmt_pkg::t1fmt_status_s [3:0] prm_status,
   input wire logic prm_start,
   output logic prm_busy,
   output logic tx_line_bit,
   input wire logic rx_line_bit,
   output logic rx_data_out,
   output logic rx_sig_valid,
   output t1fmt_pkg::t1fmt_sig_s rx_sig,
   output logic rx_link_bit,
   output logic rx_link_valid,
   output t1fmt_pkg::t1fmt_scfield_s rx_scfield,
   output logic rx_pattern_err,
   output logic rx_crc_err,
   output logic [7:0] bit_pos,
   output logic [6:0] frame_num
);
   localparam int FB = t1fmt_pkg::FRAME_BITS;
   logic [7:0] bit_q;
   logic [6:0] frm_q;
   logic [6:0] nfrm;
   logic fbit_slot;
   logic robbed;
   logic [1:0] sig_idx;
   logic ovh_bit;
   logic ovh_check;
   logic exp_bit;
   logic [5:0] crc_q;
   logic [5:0] crc_hold_q;
   logic [5:0] rx_crc_q;
   logic [5:0] rx_crc_hold_q;
   logic [5:0] rx_cbits_q;
   logic [2:0] lnk_cnt_q;
   logic [7:0] lnk_sh_q;
   logic lnk_pop;
   logic [7:0] fifo_out;
   logic fifo_valid;
   logic [7:0] prm_octet;
   logic prm_valid;
   logic [3:0] prm_idx_q;
   logic [15:0] fcs_q;
   logic [3:0] pair;
   logic tx_bit;
   logic tx_link_ready_raw;

   typedef enum logic [2:0] {
      T1FMT_PRM_IDLE = 3'h1,
      T1FMT_PRM_SEND = 3'h2,
      T1FMT_PRM_FCS = 3'h4
   } t1fmt_prm_e;
   t1fmt_prm_e prm_q;

   // frame position: bit 0 is the f-bit, then 24 x 8 traffic bits
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         bit_q <= '0;
         frm_q <= '0;
      end else if (bit_q == 8'(FB-1)) begin
         bit_q <= '0;
         frm_q <= (frm_q == nfrm - 7'h01) ? '0 : frm_q + 7'h01;
      end else begin
         bit_q <= bit_q + 8'h01;
      end
   end
   assign nfrm = (mode == t1fmt_pkg::T1FMT_MODE_ESF) ? 7'(t1fmt_pkg::ESF_FRAMES) :
                 (mode == t1fmt_pkg::T1FMT_MODE_SC) ? 7'(t1fmt_pkg::SC_FRAMES) : 7'(t1fmt_pkg::SF_FRAMES);
   assign bit_pos = bit_q;
   assign frame_num = frm_q + 7'h01;
   assign fbit_slot = (bit_q == 8'h00);

   // robbed frames: 6 and 12 in sf, every sixth frame up to 72 in sc, 6/12/18/24 in esf
   always_comb begin
      robbed = (bit_q[2:0] == 3'h0) && !fbit_slot && (frame_num % 7'h06 == 7'h00);
      sig_idx = 2'((frame_num / 7'h06 - 7'h01) % ((mode == t1fmt_pkg::T1FMT_MODE_ESF) ? 7'h04 : 7'h02));
      case (sig_variant)
         t1fmt_pkg::T1FMT_SIG_4: sig_idx = {1'b0, sig_idx[0]};
         t1fmt_pkg::T1FMT_SIG_2: sig_idx = 2'h0;
         default: sig_idx = sig_idx;
      endcase
   end

   // f-bit content for the current frame; ovh_check marks fixed framing bits
   always_comb begin
      ovh_bit = 1'b1;
      ovh_check = 1'b0;
      exp_bit = 1'b0;
      case (mode)
         t1fmt_pkg::T1FMT_MODE_ESF: begin
            if (!frm_q[0]) begin
               ovh_bit = lnk_sh_q[0];
            end else if (frm_q[1:0] == 2'h3) begin
               exp_bit = t1fmt_pkg::FPS_PATTERN[5 - 3'(frm_q[6:2])];
               ovh_bit = exp_bit;
               ovh_check = 1'b1;
            end else begin
               ovh_bit = crc_hold_q[5 - 3'(frm_q[6:2])];
            end
         end
         default: begin
            if (!frm_q[0]) begin
               exp_bit = t1fmt_pkg::FT_PATTERN[5 - 3'((frm_q % 7'h0C) >> 1)];
               ovh_bit = exp_bit;
               ovh_check = 1'b1;
            end else if (mode == t1fmt_pkg::T1FMT_MODE_SC && frame_num >= 7'(t1fmt_pkg::SC_C_FIRST)
                         && frame_num != 7'd46 && frame_num != 7'd48 && frame_num < 7'd70
                         && frame_num != 7'd50) begin
               ovh_bit = sc_field(tx_scfield, frame_num);
            end else if (mode == t1fmt_pkg::T1FMT_MODE_SC && frame_num >= 7'(t1fmt_pkg::SC_C_FIRST)) begin
               exp_bit = (frame_num == 7'd46 || frame_num == 7'd50 || frame_num == 7'd72) ?
                         t1fmt_pkg::SPOILER_46_48_70[1] : t1fmt_pkg::SPOILER_46_48_70[0];
               ovh_bit = exp_bit;
               ovh_check = 1'b1;
            end else begin
               exp_bit = t1fmt_pkg::FS_PATTERN[5 - 3'((frm_q % 7'h0C) >> 1)];
               ovh_bit = exp_bit;
               ovh_check = 1'b1;
            end
         end
      endcase
   end

   // field bit for an even subscriber frame in the 72-frame cycle
   function automatic logic sc_field(input t1fmt_pkg::t1fmt_scfield_s f, input logic [6:0] n);
      logic r;
      r = 1'b0;
      if (n <= 7'(t1fmt_pkg::SC_C_LAST)) begin
         r = f.conc[4'((n - 7'(t1fmt_pkg::SC_C_FIRST)) >> 1)];
      end else if (n >= 7'(t1fmt_pkg::SC_M_FIRST) && n <= 7'(t1fmt_pkg::SC_M_LAST)) begin
         r = f.maint[2'((n - 7'(t1fmt_pkg::SC_M_FIRST)) >> 1)];
      end else if (n >= 7'(t1fmt_pkg::SC_A_FIRST) && n <= 7'(t1fmt_pkg::SC_A_LAST)) begin
         r = f.alarm[1'((n - 7'(t1fmt_pkg::SC_A_FIRST)) >> 1)];
      end else if (n >= 7'(t1fmt_pkg::SC_S_FIRST)) begin
         r = f.lsw[2'((n - 7'(t1fmt_pkg::SC_S_FIRST)) >> 1)];
      end
      return r;
   endfunction : sc_field

   assign tx_bit = fbit_slot ? ovh_bit : (robbed ? tx_sig.abcd[sig_idx] : tx_data_in);

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         tx_line_bit <= 1'b1;
         rx_data_out <= 1'b0;
      end else begin
         tx_line_bit <= tx_bit;
         rx_data_out <= rx_line_bit;
      end
   end

   // crc over the multiframe, f-bits taken as 1; result used in the next multiframe
   function automatic logic [5:0] crc_step(input logic [5:0] c, input logic b);
      logic fb;
      fb = c[5] ^ b;
      return {c[4:0], 1'b0} ^ (fb ? t1fmt_pkg::CRC_POLY[5:0] : 6'h00);
   endfunction : crc_step

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         crc_q <= '0;
         crc_hold_q <= '0;
         rx_crc_q <= '0;
         rx_crc_hold_q <= '0;
         rx_cbits_q <= '0;
         rx_crc_err <= 1'b0;
      end else if (mode == t1fmt_pkg::T1FMT_MODE_ESF) begin
         if (fbit_slot && frm_q == '0) begin
            crc_hold_q <= crc_q;
            rx_crc_hold_q <= rx_crc_q;
            rx_crc_err <= (rx_cbits_q != rx_crc_hold_q);
            crc_q <= crc_step(6'h00, 1'b1);
            rx_crc_q <= crc_step(6'h00, 1'b1);
         end else begin
            crc_q <= crc_step(crc_q, fbit_slot | tx_bit);
            rx_crc_q <= crc_step(rx_crc_q, fbit_slot | rx_line_bit);
         end
         if (fbit_slot && frm_q[1:0] == 2'h1) begin
            rx_cbits_q[5 - 3'(frm_q[6:2])] <= rx_line_bit;
         end
      end else begin
         rx_crc_err <= 1'b0;
      end
   end

   // receive extraction: f-bit checks, data link, signaling, subscriber fields
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rx_pattern_err <= 1'b0;
         rx_link_bit <= 1'b0;
         rx_link_valid <= 1'b0;
         rx_sig_valid <= 1'b0;
         rx_sig <= '0;
         rx_scfield <= '0;
      end else begin
         rx_pattern_err <= fbit_slot && ovh_check && (rx_line_bit != exp_bit);
         rx_link_valid <= fbit_slot && (mode == t1fmt_pkg::T1FMT_MODE_ESF) && !frm_q[0];
         rx_link_bit <= rx_line_bit;
         rx_sig_valid <= robbed;
         if (robbed) begin
            rx_sig.abcd[sig_idx] <= rx_line_bit;
         end
         if (fbit_slot && mode == t1fmt_pkg::T1FMT_MODE_SC && frm_q[0]) begin
            if (frame_num >= 7'(t1fmt_pkg::SC_C_FIRST) && frame_num <= 7'(t1fmt_pkg::SC_C_LAST)) begin
               rx_scfield.conc[4'((frame_num - 7'(t1fmt_pkg::SC_C_FIRST)) >> 1)] <= rx_line_bit;
            end else if (frame_num >= 7'(t1fmt_pkg::SC_M_FIRST) && frame_num <= 7'(t1fmt_pkg::SC_M_LAST)) begin
               rx_scfield.maint[2'((frame_num - 7'(t1fmt_pkg::SC_M_FIRST)) >> 1)] <= rx_line_bit;
            end else if (frame_num >= 7'(t1fmt_pkg::SC_A_FIRST) && frame_num <= 7'(t1fmt_pkg::SC_A_LAST)) begin
               rx_scfield.alarm[1'((frame_num - 7'(t1fmt_pkg::SC_A_FIRST)) >> 1)] <= rx_line_bit;
            end else if (frame_num >= 7'(t1fmt_pkg::SC_S_FIRST) && frame_num <= 7'(t1fmt_pkg::SC_S_LAST)) begin
               rx_scfield.lsw[2'((frame_num - 7'(t1fmt_pkg::SC_S_FIRST)) >> 1)] <= rx_line_bit;
            end
         end
      end
   end

   // link octets queue ahead of the serialiser; a report takes priority at the fifo input
   t1fmt_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .sys_clk(sys_clk),
      .reset(reset),
      .in_data(prm_valid ? prm_octet : tx_link_octet),
      .in_valid(prm_valid | tx_link_valid),
      .in_ready(tx_link_ready_raw),
      .out_data(fifo_out),
      .out_valid(fifo_valid),
      .out_ready(lnk_pop)
   );
   assign tx_link_ready = tx_link_ready_raw && !prm_valid;
   assign prm_busy = (prm_q != T1FMT_PRM_IDLE);

   // serialiser: lsb first, one bit per odd esf frame; idle sends flags
   assign lnk_pop = fbit_slot && !frm_q[0] && (lnk_cnt_q == 3'h7) && (mode == t1fmt_pkg::T1FMT_MODE_ESF);
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         lnk_cnt_q <= 3'h0;
         lnk_sh_q <= t1fmt_pkg::PRM_FLAG;
      end else if (fbit_slot && !frm_q[0] && mode == t1fmt_pkg::T1FMT_MODE_ESF) begin
         lnk_cnt_q <= lnk_cnt_q + 3'h1;
         if (lnk_cnt_q == 3'h7) begin
            lnk_sh_q <= fifo_valid ? fifo_out : t1fmt_pkg::PRM_FLAG;
         end else begin
            lnk_sh_q <= {1'b0, lnk_sh_q[7:1]};
         end
      end
   end

   // report octet builder; zero-bit stuffing is left to a downstream hdlc stage
   always_comb begin
      pair = 4'(prm_idx_q - 4'h4) >> 1;
      prm_octet = 8'h00;
      case (prm_idx_q)
         4'h0: prm_octet = t1fmt_pkg::PRM_FLAG;
         4'h1: prm_octet = t1fmt_pkg::PRM_ADDR_HI;
         4'h2: prm_octet = t1fmt_pkg::PRM_ADDR_LO;
         4'h3: prm_octet = t1fmt_pkg::PRM_CONTROL;
         4'hC: prm_octet = ~fcs_q[15:8];
         4'hD: prm_octet = ~fcs_q[7:0];
         default: begin
            if (!prm_idx_q[0]) begin
               prm_octet = {prm_status[pair[1:0]].g6, prm_status[pair[1:0]].sl, prm_status[pair[1:0]].g5,
                            1'b0, 1'b0, prm_status[pair[1:0]].g4, prm_status[pair[1:0]].lv,
                            prm_status[pair[1:0]].g3};
            end else begin
               prm_octet = {prm_status[pair[1:0]].ni, prm_status[pair[1:0]].nm, prm_status[pair[1:0]].g2,
                            1'b0, prm_status[pair[1:0]].g1, prm_status[pair[1:0]].lb,
                            prm_status[pair[1:0]].se, prm_status[pair[1:0]].fe};
            end
         end
      endcase
   end
   assign prm_valid = (prm_q != T1FMT_PRM_IDLE);

   function automatic logic [15:0] fcs_byte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ t1fmt_pkg::FCS_POLY_R) : (r >> 1);
      end
      return r;
   endfunction : fcs_byte

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         prm_q <= T1FMT_PRM_IDLE;
         prm_idx_q <= '0;
         fcs_q <= t1fmt_pkg::FCS_INIT;
      end else begin
         case (prm_q)
            T1FMT_PRM_IDLE: begin
               if (prm_start) begin
                  prm_q <= T1FMT_PRM_SEND;
                  prm_idx_q <= '0;
                  fcs_q <= t1fmt_pkg::FCS_INIT;
               end
            end
            T1FMT_PRM_SEND: begin
               if (tx_link_ready_raw) begin
                  if (prm_idx_q != 4'h0) begin
                     fcs_q <= fcs_byte(fcs_q, prm_octet);
                  end
                  prm_idx_q <= prm_idx_q + 4'h1;
                  if (prm_idx_q == 4'hB) begin
                     prm_q <= T1FMT_PRM_FCS;
                  end
               end
            end
            T1FMT_PRM_FCS: begin
               if (tx_link_ready_raw) begin
                  prm_idx_q <= prm_idx_q + 4'h1;
                  if (prm_idx_q == 4'(t1fmt_pkg::PRM_OCTETS - 1)) begin
                     prm_q <= T1FMT_PRM_IDLE;
                  end
               end
            end
            default: prm_q <= T1FMT_PRM_IDLE;
         endcase
      end
   end
endmodule : t1fmt_core

// ==== inc/t1fmt_pkg.sv ====
// package: frame geometry, overhead patterns and carriers for the t1 overhead formatter
package t1fmt_pkg;
   localparam int SLOTS = 24;
   localparam int SLOT_BITS = 8;
   localparam int FRAME_BITS = 193;
   localparam int ESF_FRAMES = 24;
   localparam int SF_FRAMES = 12;
   localparam int SC_FRAMES = 72;
   localparam int PRM_OCTETS = 14;
   localparam int CRC_W = 6;
   localparam logic [6:0] CRC_POLY = 7'h43;
   localparam logic [5:0] FPS_PATTERN = 6'h0B;
   localparam logic [5:0] FT_PATTERN = 6'h2A;
   localparam logic [5:0] FS_PATTERN = 6'h0E;
   localparam logic [7:0] PRM_FLAG = 8'h7E;
   localparam logic [7:0] PRM_ADDR_HI = 8'h38;
   localparam logic [7:0] PRM_ADDR_LO = 8'h01;
   localparam logic [7:0] PRM_CONTROL = 8'h03;
   localparam logic [15:0] FCS_INIT = 16'hFFFF;
   localparam logic [15:0] FCS_POLY_R = 16'h8408;
   localparam int SC_C_FIRST = 24;
   localparam int SC_C_LAST = 44;
   localparam int SC_M_FIRST = 52;
   localparam int SC_M_LAST = 56;
   localparam int SC_A_FIRST = 58;
   localparam int SC_A_LAST = 60;
   localparam int SC_S_FIRST = 62;
   localparam int SC_S_LAST = 68;
   localparam logic [1:0] SPOILER_46_48_70 = 2'h1;

   typedef enum logic [3:0] {
      T1FMT_MODE_ESF = 4'h1,
      T1FMT_MODE_SF = 4'h2,
      T1FMT_MODE_SC = 4'h4
   } t1fmt_mode_e;

   typedef enum logic [1:0] {
      T1FMT_SIG_16 = 2'h0,
      T1FMT_SIG_4 = 2'h1,
      T1FMT_SIG_2 = 2'h2
   } t1fmt_sig_e;

   // one status pair of the one-second report
   typedef struct packed {
      logic g1, g2, g3, g4, g5, g6;
      logic lv, sl, fe, se, lb, nm, ni;
   } t1fmt_status_s;

   // subscriber-carrier even-frame fields
   typedef struct packed {
      logic [10:0] conc;
      logic [2:0] maint;
      logic [1:0] alarm;
      logic [3:0] lsw;
   } t1fmt_scfield_s;

   typedef struct packed {
      logic [3:0] abcd;
   } t1fmt_sig_s;
endpackage : t1fmt_pkg

// ==== rtl/t1fmt_fifo.sv ====
// fifo: parameterised flip-flop queue with valid/ready on both sides
`timescale 1ns/1ps
module t1fmt_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : t1fmt_fifo

// ==== tb/t1fmt_monitor.sv ====
// checker: frame counting and overhead placement seen at the formatter ports
`timescale 1ns/1ps
module t1fmt_monitor (
   input wire logic sys_clk,
   input wire logic reset,
   input wire t1fmt_pkg::t1fmt_mode_e mode,
   input wire t1fmt_pkg::t1fmt_sig_e sig_variant,
   input wire logic tx_data_in,
   input wire t1fmt_pkg::t1fmt_sig_s tx_sig,
   input wire t1fmt_pkg::t1fmt_scfield_s tx_scfield,
   input wire logic tx_line_bit,
   input wire logic rx_link_valid,
   input wire logic rx_line_bit,
   input wire logic rx_data_out,
   input wire logic rx_sig_valid,
   input wire logic [7:0] bit_pos,
   input wire logic [6:0] frame_num
);
   logic esf, sf, sc, fb;
   logic [6:0] last_f;
   assign esf = mode == t1fmt_pkg::T1FMT_MODE_ESF;
   assign sf = mode == t1fmt_pkg::T1FMT_MODE_SF;
   assign sc = mode == t1fmt_pkg::T1FMT_MODE_SC;
   assign fb = bit_pos == 8'h00;
   assign last_f = esf ? 7'h18 : (sf ? 7'h0C : 7'h48);
   default clocking mon_cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   a_frame_end: assert property (bit_pos == 8'hC0 |=> fb)
      else $error("frame length not 193 bits");
   a_bit_step: assert property (bit_pos != 8'hC0 |=> bit_pos == $past(bit_pos) + 8'h01)
      else $error("bit position skipped");
   a_multi_wrap: assert property (bit_pos == 8'hC0 && frame_num == last_f |=> frame_num == 7'h01)
      else $error("multiframe length wrong");
   a_frame_step: assert property (bit_pos == 8'hC0 && frame_num != last_f |=> frame_num == $past(frame_num) + 7'h01)
      else $error("frame number skipped");
   a_align_pattern: assert property (esf && fb && frame_num[1:0] == 2'h0
      |=> tx_line_bit == (frame_num inside {7'h0C, 7'h14, 7'h18})) else $error("alignment bit wrong");
   a_sf_terminal: assert property ((sf || sc) && fb && frame_num[0] |=> tx_line_bit == !frame_num[1])
      else $error("terminal framing bit wrong");
   a_sf_signaling: assert property (sf && fb && !frame_num[0]
      |=> tx_line_bit == (frame_num inside {7'h06, 7'h08, 7'h0A})) else $error("signaling framing bit wrong");
   a_spoiler_bits: assert property (sc && fb && frame_num inside {7'h2E, 7'h30, 7'h46}
      |=> tx_line_bit == (frame_num != 7'h2E)) else $error("spoiler bit wrong");
   a_conc_first: assert property (sc && fb && frame_num == 7'h18 |=> tx_line_bit == $past(tx_scfield.conc[0]))
      else $error("first concentrator bit wrong");
   a_robbed_sig: assert property (esf && sig_variant == t1fmt_pkg::T1FMT_SIG_16 && frame_num == 7'h06
      && !fb && bit_pos[2:0] == 3'h0 |=> tx_line_bit == $past(tx_sig.abcd[0])) else $error("robbed bit wrong");
   a_traffic_pass: assert property (!fb && bit_pos[2:0] != 3'h0 |=> tx_line_bit == $past(tx_data_in))
      else $error("traffic bit not passed");
   a_link_extract: assert property (esf && fb && frame_num[0] |-> ##[1:2] rx_link_valid)
      else $error("link bit not extracted");
   a_rx_copy: assert property (1'b1 |=> rx_data_out == $past(rx_line_bit))
      else $error("receive copy wrong");
   a_sig_strobe: assert property (esf && !fb && bit_pos[2:0] == 3'h0 && frame_num == 7'h06 |=> rx_sig_valid)
      else $error("signaling strobe missing");
endmodule : t1fmt_monitor

// ==== tb/t1fmt_line_model.sv ====
// partner: remote terminal sending an aligned line stream with good esf and sf overhead
`timescale 1ns/1ps
module t1fmt_line_model (
   input wire logic sys_clk,
   input wire logic reset,
   input wire t1fmt_pkg::t1fmt_mode_e mode,
   input wire logic [7:0] bit_pos,
   input wire logic [6:0] frame_num,
   input wire logic [1:0] err_kind,
   output logic rx_line_bit
);
   logic [5:0] crc_q, chk_q, crc_d;
   logic [2:0] link_q;
   logic clean, flip, esf;
   int fn;
   assign fn = int'(frame_num);
   assign esf = mode == t1fmt_pkg::T1FMT_MODE_ESF;
   always_comb begin
      clean = bit_pos[0] ^ bit_pos[3];
      if (bit_pos != 8'h00 && bit_pos[2:0] == 3'h0 && fn % 6 == 0) begin
         clean = fn == 6 || fn == 24;
      end
      if (bit_pos == 8'h00) begin
         if (!esf) begin
            clean = fn % 2 == 1 ? t1fmt_pkg::FT_PATTERN[5 - ((fn - 1) / 2) % 6]
               : t1fmt_pkg::FS_PATTERN[5 - (fn / 2 - 1) % 6];
         end else if (fn % 4 == 0) begin
            clean = t1fmt_pkg::FPS_PATTERN[6 - fn / 4];
         end else if (fn % 4 == 2) begin
            clean = chk_q[5 - (fn - 2) / 4];
         end else begin
            clean = t1fmt_pkg::PRM_FLAG[link_q];
         end
      end
   end
   // flips only on command, so the check value still covers the clean stream
   assign flip = (err_kind[0] && esf && bit_pos == 8'h00 && fn % 4 == 0) || (err_kind[1] && fn == 3 && bit_pos == 8'h05);
   assign rx_line_bit = clean ^ flip;
   assign crc_d = {crc_q[4:0], 1'b0} ^ (((bit_pos == 8'h00 || clean) ^ crc_q[5]) ? t1fmt_pkg::CRC_POLY[5:0] : 6'h00);
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         crc_q <= 6'h00;
         chk_q <= 6'h00;
      end else if (bit_pos == 8'hC0 && fn == 24) begin
         crc_q <= 6'h00;
         chk_q <= crc_d;
      end else begin
         crc_q <= crc_d;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         link_q <= 3'h0;
      end else if (bit_pos == 8'h00 && fn % 2 == 1) begin
         link_q <= link_q + 3'h1;
      end
   end
endmodule : t1fmt_line_model

// ==== tb/t1fmt_core_test.sv ====
// testbench: placement rows, link queue, report head and receive checks
`timescale 1ns/1ps
module t1fmt_core_test;
   typedef struct {int m; int v; int f; int p; int e;} t1fmt_row_s;
   logic sys_clk = 1'b0, reset = 1'b1, tx_data_in = 1'b0, tx_link_valid = 1'b0, prm_start = 1'b0;
   t1fmt_pkg::t1fmt_mode_e mode = t1fmt_pkg::T1FMT_MODE_ESF;
   t1fmt_pkg::t1fmt_sig_e sig_variant = t1fmt_pkg::T1FMT_SIG_16;
   t1fmt_pkg::t1fmt_sig_s tx_sig = 4'h9;
   t1fmt_pkg::t1fmt_scfield_s tx_scfield = {11'h401, 3'h1, 2'h2, 4'h1};
   t1fmt_pkg::t1fmt_status_s [3:0] prm_status = '0;
   t1fmt_pkg::t1fmt_sig_s rx_sig;
   t1fmt_pkg::t1fmt_scfield_s rx_scfield;
   logic [7:0] tx_link_octet = 8'h00, bit_pos;
   logic [6:0] frame_num;
   logic [1:0] err_kind = 2'h0;
   logic tx_link_ready, prm_busy, tx_line_bit, rx_line_bit, rx_data_out, rx_sig_valid, rx_link_bit;
   logic rx_link_valid, rx_pattern_err, rx_crc_err;
   logic [47:0] sr;
   int n_fail = 0, tests_run = 0, cyc = 0, n_perr = 0;
   t1fmt_row_s rows [32] = '{'{1,0,4,0,0}, '{1,0,5,8,0}, '{1,0,6,7,1}, '{1,0,6,8,1}, '{1,0,8,0,0},
      '{1,0,12,0,1}, '{1,0,12,8,0}, '{1,0,16,0,0}, '{1,0,18,8,0}, '{1,0,20,0,1}, '{1,0,24,0,1}, '{1,0,24,8,1},
      '{1,1,18,8,1}, '{1,1,24,8,0}, '{1,2,12,8,1}, '{1,2,24,8,1}, '{2,0,1,0,1}, '{2,0,2,0,0}, '{2,0,3,0,0},
      '{2,0,6,0,1}, '{2,0,12,0,0}, '{4,0,6,0,1}, '{4,0,24,0,1}, '{4,0,26,0,0}, '{4,0,44,0,1}, '{4,0,46,0,0},
      '{4,0,48,0,1}, '{4,0,52,0,1}, '{4,0,58,0,0}, '{4,0,60,0,1}, '{4,0,62,0,1}, '{4,0,70,0,1}};
   t1fmt_core #(.FIFO_DEPTH(4)) u_dut (.sys_clk(sys_clk), .reset(reset), .mode(mode), .sig_variant(sig_variant),
      .tx_data_in(tx_data_in), .tx_sig(tx_sig), .tx_scfield(tx_scfield), .tx_link_octet(tx_link_octet),
      .tx_link_valid(tx_link_valid), .tx_link_ready(tx_link_ready), .prm_status(prm_status),
      .prm_start(prm_start), .prm_busy(prm_busy), .tx_line_bit(tx_line_bit), .rx_line_bit(rx_line_bit),
      .rx_data_out(rx_data_out), .rx_sig_valid(rx_sig_valid), .rx_sig(rx_sig), .rx_link_bit(rx_link_bit),
      .rx_link_valid(rx_link_valid), .rx_scfield(rx_scfield), .rx_pattern_err(rx_pattern_err),
      .rx_crc_err(rx_crc_err), .bit_pos(bit_pos), .frame_num(frame_num));
   t1fmt_line_model u_far (.sys_clk(sys_clk), .reset(reset), .mode(mode), .bit_pos(bit_pos),
      .frame_num(frame_num), .err_kind(err_kind), .rx_line_bit(rx_line_bit));
   always #5 sys_clk = ~sys_clk;
   always @(negedge sys_clk) tx_data_in <= bit_pos[0];
   always @(posedge sys_clk) begin
      if (!reset && rx_pattern_err === 1'b1) n_perr++;
   end
   // ceiling sits above the summed multiframe waits of all tests
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 100000) begin
         n_fail++;
         $display("BAD timeout expected finish seen hang");
         summarize();
      end
   end
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : summarize
   task automatic cmp1(input string nm, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %b seen %b", nm, e, g);
      end
   endtask : cmp1
   task automatic cmp4(input string nm, input logic [3:0] e, input logic [3:0] g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp4
   task automatic start(input int m, input int v);
      @(negedge sys_clk);
      reset = 1'b1;
      mode = t1fmt_pkg::t1fmt_mode_e'(4'(m));
      sig_variant = t1fmt_pkg::t1fmt_sig_e'(2'(v));
      repeat (5) @(negedge sys_clk);
      reset = 1'b0;
   endtask : start
   // f of 0 means any odd frame; returns one cycle later, when the line bit is out
   task automatic seek(input int f, input int p);
      while (!(bit_pos == 8'(p) && (f == 0 ? frame_num[0] : frame_num == 7'(f)))) @(negedge sys_clk);
      @(negedge sys_clk);
   endtask : seek
   task automatic hunt(input int nb, input logic [47:0] want, input logic [47:0] mask, input string nm);
      logic hit;
      int n;
      hit = 1'b0;
      sr = '0;
      for (n = 0; n < nb && !hit; n++) begin
         seek(0, 0);
         sr = {tx_line_bit, sr[47:1]};
         hit = (sr & mask) === want;
      end
      cmp1(nm, 1'b1, hit);
   endtask : hunt
   task automatic push(input logic [7:0] o);
      int n;
      n = 0;
      tx_link_octet = o;
      tx_link_valid = 1'b1;
      // ready is registered-state only, so its value here holds through the next rising edge
      while (tx_link_ready !== 1'b1 && n < 50000) begin
         n++;
         @(negedge sys_clk);
      end
      @(negedge sys_clk);
   endtask : push
   initial begin
      int cm, cv;
      cm = 0;
      cv = 0;
      repeat (5) @(negedge sys_clk);
      cmp1("reset line bit", 1'b1, tx_line_bit);
      cmp1("reset position", 1'b1, frame_num === 7'h01 && bit_pos === 8'h00);
      $display("test reset done");
      foreach (rows[i]) begin
         if (rows[i].m != cm || rows[i].v != cv) begin
            cm = rows[i].m;
            cv = rows[i].v;
            start(cm, cv);
         end
         seek(rows[i].f, rows[i].p);
         cmp1($sformatf("mode %0d frame %0d pos %0d", cm, rows[i].f, rows[i].p), 1'(rows[i].e), tx_line_bit);
      end
      $display("test placement rows done");
      start(1, 0);
      push(8'hA5);
      push(8'h3C);
      push(8'h96);
      push(8'h0F);
      cmp1("link ready when full", 1'b0, tx_link_ready);
      tx_link_valid = 1'b0;
      hunt(64, {32'h0F963CA5, 16'h0000}, {32'hFFFFFFFF, 16'h0000}, "link octet order");
      $display("test link queue done");
      start(1, 0);
      prm_status[0] = '1;
      prm_start = 1'b1;
      @(negedge sys_clk);
      prm_start = 1'b0;
      cmp1("report busy", 1'b1, prm_busy);
      cmp1("link ready during report", 1'b0, tx_link_ready);
      hunt(96, 48'hEFE70301387E, '1, "report head");
      $display("test report done");
      start(1, 0);
      n_perr = 0;
      repeat (t1fmt_pkg::ESF_FRAMES * t1fmt_pkg::FRAME_BITS * 5 / 2) @(negedge sys_clk);
      cmp4("received signaling", 4'h9, rx_sig);
      cmp1("check clean", 1'b0, rx_crc_err);
      cmp1("no pattern error", 1'b1, n_perr == 0);
      err_kind = 2'h3;
      repeat (t1fmt_pkg::ESF_FRAMES * t1fmt_pkg::FRAME_BITS * 3) @(negedge sys_clk);
      cmp1("pattern error seen", 1'b1, n_perr > 0);
      cmp1("check error seen", 1'b1, rx_crc_err);
      $display("test receive done");
      summarize();
   end
endmodule : t1fmt_core_test
bind t1fmt_core t1fmt_monitor u_mon (.sys_clk(sys_clk), .reset(reset), .mode(mode), .sig_variant(sig_variant),
   .tx_data_in(tx_data_in), .tx_sig(tx_sig), .tx_scfield(tx_scfield), .tx_line_bit(tx_line_bit),
   .rx_link_valid(rx_link_valid), .bit_pos(bit_pos), .frame_num(frame_num),
   .rx_line_bit(rx_line_bit), .rx_data_out(rx_data_out), .rx_sig_valid(rx_sig_valid));
